// ---- logic/pst_stage_timer.sv ----
// Operate and release timing of one protection stage, with APB registers.
`timescale 1ns/1ps
`default_nettype none
module pst_stage_timer #(
  parameter int unsigned MS_TICK_CYCLES = pst_pkg::MS_TICK_CYCLES
) (
  input  wire logic                  clk_sys,
  input  wire logic                  srst,
  input  wire pst_pkg::pst_apb_req_t apbReq,
  output pst_pkg::pst_apb_rsp_t      apbRsp,
  input  wire logic [15:0]           measCurrent,
  input  wire logic                  pickUp,
  output logic                       startOut,
  output logic                       tripOut,
  output logic                       blockedOut,
  output logic                       irq
);

  function automatic logic addr_mapped(input logic [11:0] a);
    case (a)
      pst_pkg::ADDR_CTRL, pst_pkg::ADDR_DIAL, pst_pkg::ADDR_PICKUP,
      pst_pkg::ADDR_RELEASE, pst_pkg::ADDR_FORCE, pst_pkg::ADDR_STATUS,
      pst_pkg::ADDR_OPDELAY, pst_pkg::ADDR_OPCOUNT,
      pst_pkg::ADDR_IRQ_STATUS, pst_pkg::ADDR_IRQ_CLEAR,
      pst_pkg::ADDR_IRQ_ENABLE: addr_mapped = 1'b1;
      default: addr_mapped = 1'b0;
    endcase
  endfunction

  typedef struct packed {
    logic [5:0]                      ctrl;
    logic [15:0]                     timeDial;
    logic [15:0]                     pickUpSetting;
    logic [15:0]                     releaseSteps;
    pst_pkg::pst_force_t             forceState;
    pst_pkg::pst_state_t             state;
    logic [31:0]                     opCount;
    logic [31:0]                     prescale;
    logic                            msTick;
    logic                            relRestart;
    logic [pst_pkg::IRQ_BITS-1:0]    irqStatus;
    logic [pst_pkg::IRQ_BITS-1:0]    irqEnable;
    logic [31:0]                     rdata;
    logic                            slverr;
    logic                            start;
    logic                            trip;
    logic                            blocked;
  } pst_top_st_t;

  pst_top_st_t st;
  pst_top_st_t next_st;

  logic [31:0] opDelayMs;
  logic        relExpired;

  logic enable;
  logic curveLog;
  logic delayedRelease;
  logic resetAfterRelease;
  logic continueRelease;
  logic forceOn;
  logic wrEn;
  logic setupRead;
  logic [pst_pkg::IRQ_BITS-1:0] events;
  logic [31:0] rdMux;

  assign enable            = st.ctrl[pst_pkg::CTRL_ENABLE_BIT];
  assign curveLog          = st.ctrl[pst_pkg::CTRL_CURVE_BIT];
  assign delayedRelease    = st.ctrl[pst_pkg::CTRL_DELAYREL_BIT];
  assign resetAfterRelease = st.ctrl[pst_pkg::CTRL_RSTAFTER_BIT];
  assign continueRelease   = st.ctrl[pst_pkg::CTRL_CONTINUE_BIT];
  assign forceOn           = st.ctrl[pst_pkg::CTRL_FORCE_BIT];

  pst_delay_calc u_delay_calc (
    .clk_sys       (clk_sys),
    .srst          (srst),
    .curveLog      (curveLog),
    .timeDial      (st.timeDial),
    .pickUpSetting (st.pickUpSetting),
    .measCurrent   (measCurrent),
    .opDelayMs     (opDelayMs)
  );

  pst_release_timer u_release_timer (
    .clk_sys      (clk_sys),
    .srst         (srst),
    .restart      (st.relRestart),
    .msTick       (st.msTick),
    .releaseSteps (st.releaseSteps),
    .expired      (relExpired)
  );

  // Read data is captured in the setup cycle so that prdata comes from
  // a flip-flop while the slave still answers with no wait states.
  always_comb begin
    rdMux = 32'h0000_0000;
    case (apbReq.paddr)
      pst_pkg::ADDR_CTRL:       rdMux = {26'h000_0000, st.ctrl};
      pst_pkg::ADDR_DIAL:       rdMux = {16'h0000, st.timeDial};
      pst_pkg::ADDR_PICKUP:     rdMux = {16'h0000, st.pickUpSetting};
      pst_pkg::ADDR_RELEASE:    rdMux = {16'h0000, st.releaseSteps};
      pst_pkg::ADDR_FORCE:      rdMux = {30'h0000_0000, st.forceState};
      pst_pkg::ADDR_STATUS:     rdMux = {26'h000_0000, pickUp,
                                         st.state, st.blocked,
                                         st.trip, st.start};
      pst_pkg::ADDR_OPDELAY:    rdMux = opDelayMs;
      pst_pkg::ADDR_OPCOUNT:    rdMux = st.opCount;
      pst_pkg::ADDR_IRQ_STATUS: rdMux = {29'h0000_0000, st.irqStatus};
      pst_pkg::ADDR_IRQ_ENABLE: rdMux = {29'h0000_0000, st.irqEnable};
      default:                  rdMux = 32'h0000_0000;
    endcase
  end

  assign wrEn      = apbReq.psel && apbReq.penable && apbReq.pwrite;
  assign setupRead = apbReq.psel && !apbReq.penable;

  always_comb begin
    next_st            = st;
    events             = '0;
    next_st.relRestart = 1'b0;

    // Millisecond time base for both the operate and release counters.
    if (st.prescale >= MS_TICK_CYCLES - 1) begin
      next_st.prescale = 32'h0000_0000;
      next_st.msTick   = 1'b1;
    end else begin
      next_st.prescale = st.prescale + 32'h0000_0001;
      next_st.msTick   = 1'b0;
    end

    // Register bus.
    if (setupRead) begin
      next_st.rdata  = apbReq.pwrite ? 32'h0000_0000 : rdMux;
      next_st.slverr = !addr_mapped(apbReq.paddr);
    end
    if (wrEn) begin
      case (apbReq.paddr)
        pst_pkg::ADDR_CTRL:       next_st.ctrl = apbReq.pwdata[5:0];
        pst_pkg::ADDR_DIAL:       next_st.timeDial = apbReq.pwdata[15:0];
        pst_pkg::ADDR_PICKUP:
          next_st.pickUpSetting = apbReq.pwdata[15:0];
        pst_pkg::ADDR_RELEASE:
          next_st.releaseSteps = apbReq.pwdata[15:0];
        pst_pkg::ADDR_FORCE:
          next_st.forceState = pst_pkg::pst_force_t'(apbReq.pwdata[1:0]);
        pst_pkg::ADDR_IRQ_ENABLE:
          next_st.irqEnable = apbReq.pwdata[pst_pkg::IRQ_BITS-1:0];
        default: ;
      endcase
    end

    // Operate and release sequence.
    if (!enable || forceOn) begin
      // Forcing parks the timing so no stale count trips on return.
      next_st.state   = pst_pkg::ST_IDLE;
      next_st.opCount = 32'h0000_0000;
    end else begin
      case (st.state)
        pst_pkg::ST_IDLE: begin
          next_st.opCount = 32'h0000_0000;
          if (pickUp) begin
            next_st.state = pst_pkg::ST_PICKUP;
          end
        end
        pst_pkg::ST_PICKUP: begin
          if (!pickUp) begin
            next_st.state      = pst_pkg::ST_RELEASE;
            next_st.relRestart = 1'b1;
            if (!resetAfterRelease && !continueRelease) begin
              next_st.opCount = 32'h0000_0000;
            end
          end else if (st.opCount >= opDelayMs) begin
            next_st.state = pst_pkg::ST_TRIP;
          end else if (st.msTick) begin
            next_st.opCount = st.opCount + 32'h0000_0001;
          end
        end
        pst_pkg::ST_RELEASE: begin
          if (pickUp) begin
            // Resumes from the held, advanced or cleared count.
            next_st.state = pst_pkg::ST_PICKUP;
          end else if (relExpired && !st.relRestart) begin
            next_st.state   = pst_pkg::ST_IDLE;
            next_st.opCount = 32'h0000_0000;
            events[pst_pkg::IRQ_RELEASE_BIT] = 1'b1;
          end else if (continueRelease && st.msTick) begin
            // Counting on, but tripping only from the pick-up state.
            next_st.opCount = st.opCount + 32'h0000_0001;
          end
        end
        pst_pkg::ST_TRIP: begin
          if (!pickUp) begin
            next_st.state   = pst_pkg::ST_IDLE;
            next_st.opCount = 32'h0000_0000;
          end
        end
        default: begin
          next_st.state = pst_pkg::ST_IDLE;
        end
      endcase
    end

    // Outputs, overridden by hand while forcing is on and the stage is enabled.
    if (enable && forceOn) begin
      next_st.start   = (st.forceState == pst_pkg::FORCE_START)
                     || (st.forceState == pst_pkg::FORCE_TRIP);
      next_st.trip    = (st.forceState == pst_pkg::FORCE_TRIP);
      next_st.blocked = (st.forceState == pst_pkg::FORCE_BLOCKED);
    end else begin
      next_st.start   = (next_st.state == pst_pkg::ST_PICKUP)
                     || (next_st.state == pst_pkg::ST_TRIP)
                     || ((next_st.state == pst_pkg::ST_RELEASE)
                         && delayedRelease);
      next_st.trip    = (next_st.state == pst_pkg::ST_TRIP);
      next_st.blocked = 1'b0;
    end
    events[pst_pkg::IRQ_START_BIT] = next_st.start && !st.start;
    events[pst_pkg::IRQ_TRIP_BIT]  = next_st.trip && !st.trip;

    // Sticky status: a new event beats a clear in the same cycle.
    next_st.irqStatus = st.irqStatus;
    if (wrEn && apbReq.paddr == pst_pkg::ADDR_IRQ_CLEAR) begin
      next_st.irqStatus = st.irqStatus
                        & ~apbReq.pwdata[pst_pkg::IRQ_BITS-1:0];
    end
    next_st.irqStatus = next_st.irqStatus | events;
  end

  always_ff @(posedge clk_sys) begin
    if (srst) begin
      st               <= '0;
      st.ctrl          <= pst_pkg::CTRL_RESET;
      st.timeDial      <= pst_pkg::DIAL_RESET;
      st.pickUpSetting <= pst_pkg::PICKUP_RESET;
      st.releaseSteps  <= pst_pkg::RELEASE_RESET;
      st.forceState    <= pst_pkg::FORCE_NORMAL;
      st.state         <= pst_pkg::ST_IDLE;
    end else begin
      st <= next_st;
    end
  end

  assign apbRsp.prdata  = st.rdata;
  assign apbRsp.pready  = 1'b1;
  assign apbRsp.pslverr = st.slverr && apbReq.psel && apbReq.penable;
  assign startOut       = st.start;
  assign tripOut        = st.trip;
  assign blockedOut     = st.blocked;
  assign irq            = |(st.irqStatus & st.irqEnable);

endmodule // pst_stage_timer
`default_nettype wire

// ---- logic/pst_pkg.sv ----
// Constants, types and register map of the protection stage delay timer.
package pst_pkg;

  localparam int unsigned CLK_PERIOD_NS  = 10;
  localparam int unsigned MS_TIME_NS     = 1_000_000;
  localparam int unsigned MS_TICK_CYCLES = MS_TIME_NS / CLK_PERIOD_NS;
  localparam int unsigned RELEASE_STEP_MS = 5;

  localparam logic [11:0] ADDR_CTRL       = 12'h000;
  localparam logic [11:0] ADDR_DIAL       = 12'h004;
  localparam logic [11:0] ADDR_PICKUP     = 12'h008;
  localparam logic [11:0] ADDR_RELEASE    = 12'h00C;
  localparam logic [11:0] ADDR_FORCE      = 12'h010;
  localparam logic [11:0] ADDR_STATUS     = 12'h014;
  localparam logic [11:0] ADDR_OPDELAY    = 12'h018;
  localparam logic [11:0] ADDR_OPCOUNT    = 12'h01C;
  localparam logic [11:0] ADDR_IRQ_STATUS = 12'h020;
  localparam logic [11:0] ADDR_IRQ_CLEAR  = 12'h024;
  localparam logic [11:0] ADDR_IRQ_ENABLE = 12'h028;

  localparam int unsigned CTRL_ENABLE_BIT   = 0;
  localparam int unsigned CTRL_CURVE_BIT    = 1;
  localparam int unsigned CTRL_DELAYREL_BIT = 2;
  localparam int unsigned CTRL_RSTAFTER_BIT = 3;
  localparam int unsigned CTRL_CONTINUE_BIT = 4;
  localparam int unsigned CTRL_FORCE_BIT    = 5;
  localparam logic [5:0]  CTRL_RESET        = 6'h0C;
  localparam logic [15:0] DIAL_RESET        = 16'h0005;
  localparam logic [15:0] PICKUP_RESET      = 16'h0064;
  localparam logic [15:0] RELEASE_RESET     = 16'h000C;

  localparam int unsigned IRQ_START_BIT   = 0;
  localparam int unsigned IRQ_TRIP_BIT    = 1;
  localparam int unsigned IRQ_RELEASE_BIT = 2;
  localparam int unsigned IRQ_BITS        = 3;

  localparam logic [16:0] MECH_NUM_Q16   = 17'h0_56C9;
  localparam logic [15:0] MECH_SLOPE_Q16 = 16'h3C6A;
  localparam logic [15:0] DIAL_TO_MS     = 16'h000A;
  localparam logic [15:0] DIAL_SCALE     = 16'h0064;
  localparam logic [31:0] LOG_BASE_MS    = 32'h0000_16A8;
  localparam logic [15:0] LOG_SLOPE_MS   = 16'h03A8;
  localparam logic [31:0] DELAY_MAX      = 32'hFFFF_FFFF;

  typedef enum logic [1:0] {
    ST_IDLE    = 2'b00,
    ST_PICKUP  = 2'b01,
    ST_RELEASE = 2'b11,
    ST_TRIP    = 2'b10
  } pst_state_t;

  typedef enum logic [1:0] {
    FORCE_NORMAL  = 2'b00,
    FORCE_START   = 2'b01,
    FORCE_TRIP    = 2'b10,
    FORCE_BLOCKED = 2'b11
  } pst_force_t;

  typedef struct packed {
    logic        psel;
    logic        penable;
    logic        pwrite;
    logic [11:0] paddr;
    logic [31:0] pwdata;
  } pst_apb_req_t;

  typedef struct packed {
    logic [31:0] prdata;
    logic        pready;
    logic        pslverr;
  } pst_apb_rsp_t;

endpackage

// ---- logic/pst_delay_calc.sv ----
// Inverse-time operating delay calculator for the two non-standard curves.
`timescale 1ns/1ps
`default_nettype none
module pst_delay_calc (
  input  wire logic        clk_sys,
  input  wire logic        srst,
  input  wire logic        curveLog,
  input  wire logic [15:0] timeDial,
  input  wire logic [15:0] pickUpSetting,
  input  wire logic [15:0] measCurrent,
  output logic      [31:0] opDelayMs
);

  function automatic logic [5:0] msb_pos(input logic [39:0] v);
    msb_pos = 6'd0;
    for (int i = 0; i < 40; i++) begin
      if (v[i]) begin
        msb_pos = 6'(i);
      end
    end
  endfunction

  typedef struct packed {
    logic [31:0] delay;
  } pst_calc_st_t;

  pst_calc_st_t st;
  pst_calc_st_t next_st;

  logic [27:0]        ratioQ12;
  logic signed [33:0] denomQ16;
  logic [47:0]        mechMs;
  logic [39:0]        xQ8;
  logic [31:0]        logDen;
  logic [5:0]         msb;
  logic [39:0]        norm;
  logic signed [15:0] log2Q8;
  logic signed [31:0] logMs;

  always_comb begin
    next_st  = st;
    ratioQ12 = (measCurrent == 16'h0000) ? 28'hFFF_FFFF
             : 28'({pickUpSetting, 12'h000} / {12'h000, measCurrent});
    denomQ16 = 34'(signed'({17'h0_0000, pst_pkg::MECH_NUM_Q16}))
             - 34'(({28'h000_0000, pst_pkg::MECH_SLOPE_Q16}
                    * {16'h0000, ratioQ12}) >> 12);
    mechMs   = 48'h0000_0000_0000;
    if (denomQ16 > 34'sd0) begin
      mechMs = ({16'h0000,
                 32'(timeDial) * 32'(pst_pkg::DIAL_TO_MS)} << 16)
             / {14'h0000, denomQ16};
    end
    logDen   = timeDial * pickUpSetting;
    xQ8      = (logDen == 32'h0000_0000) ? 40'hFF_FFFF_FFFF
             : ({32'(measCurrent) * 32'(pst_pkg::DIAL_SCALE), 8'h00}
                / {8'h00, logDen});
    msb      = msb_pos(xQ8);
    norm     = xQ8 << (6'd39 - msb);
    log2Q8   = 16'(signed'({10'h000, msb} - 16'sd8) * 16'sd256)
             + signed'({8'h00, norm[38:31]});
    logMs    = signed'(pst_pkg::LOG_BASE_MS)
             - ((signed'({16'h0000, pst_pkg::LOG_SLOPE_MS})
                 * 32'(log2Q8)) >>> 8);
    if (curveLog) begin
      next_st.delay = (logMs < 0) ? 32'h0000_0000 : logMs;
    end else if (denomQ16 <= 34'sd0 || mechMs[47:32] != 16'h0000) begin
      next_st.delay = pst_pkg::DELAY_MAX;
    end else begin
      next_st.delay = mechMs[31:0];
    end
  end

  always_ff @(posedge clk_sys) begin
    if (srst) begin
      st <= '{delay: pst_pkg::DELAY_MAX};
    end else begin
      st <= next_st;
    end
  end

  assign opDelayMs = st.delay;

endmodule // pst_delay_calc
`default_nettype wire

// ---- logic/pst_release_timer.sv ----
// Release period timer counting millisecond ticks against the set delay.
`timescale 1ns/1ps
`default_nettype none
module pst_release_timer (
  input  wire logic        clk_sys,
  input  wire logic        srst,
  input  wire logic        restart,
  input  wire logic        msTick,
  input  wire logic [15:0] releaseSteps,
  output logic             expired
);

  typedef struct packed {
    logic [19:0] count;
  } pst_rel_st_t;

  pst_rel_st_t st;
  pst_rel_st_t next_st;
  logic [19:0] limitMs;

  always_comb begin
    next_st = st;
    limitMs = 20'(releaseSteps * pst_pkg::RELEASE_STEP_MS);
    if (restart) begin
      next_st.count = 20'h0_0000;
    end else if (msTick && st.count < limitMs) begin
      next_st.count = st.count + 20'h0_0001;
    end
    expired = !restart && (st.count >= limitMs);
  end

  always_ff @(posedge clk_sys) begin
    if (srst) begin
      st <= '{count: 20'h0_0000};
    end else begin
      st <= next_st;
    end
  end

endmodule // pst_release_timer
`default_nettype wire

// ---- test/pst_checker.sv ----
// Port-level assertions for the protection stage delay timer.
`timescale 1ns/1ps
`default_nettype none
module pst_checker #(
  parameter int unsigned MS_TICK_CYCLES = pst_pkg::MS_TICK_CYCLES
) (
  input wire logic                  clk_sys,
  input wire logic                  srst,
  input wire pst_pkg::pst_apb_req_t apbReq,
  input wire pst_pkg::pst_apb_rsp_t apbRsp,
  input wire logic [15:0]           measCurrent,
  input wire logic                  pickUp,
  input wire logic                  startOut,
  input wire logic                  tripOut,
  input wire logic                  blockedOut,
  input wire logic                  irq
);
  // Mode shadows follow completed writes, so rules can depend on the mode.
  logic [5:0] ctrl;
  logic [1:0] frc;
  logic [15:0] rel;
  logic       wr;
  logic       frcOn;
  logic       frcAct;
  logic       run;
  assign wr = apbReq.psel && apbReq.penable && apbReq.pwrite;
  assign frcOn = ctrl[pst_pkg::CTRL_FORCE_BIT];
  // Forcing only drives the outputs while the stage is enabled.
  assign frcAct = frcOn && ctrl[pst_pkg::CTRL_ENABLE_BIT];
  assign run = ctrl[pst_pkg::CTRL_ENABLE_BIT] && !frcOn;
  always_ff @(posedge clk_sys) begin
    if (srst) begin
      ctrl <= pst_pkg::CTRL_RESET;
      frc <= 2'h0;
      rel <= pst_pkg::RELEASE_RESET;
    end else if (wr) begin
      if (apbReq.paddr == pst_pkg::ADDR_CTRL) ctrl <= apbReq.pwdata[5:0];
      if (apbReq.paddr == pst_pkg::ADDR_FORCE) frc <= apbReq.pwdata[1:0];
      if (apbReq.paddr == pst_pkg::ADDR_RELEASE) begin
        rel <= apbReq.pwdata[15:0];
      end
    end
  end
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (srst);
  sequence dropHeld;
    startOut [*8];
  endsequence
  sequence quiet;
    (!pickUp && !frcOn) [*3];
  endsequence
  a_start_rise: assert property (
    run && pickUp && !startOut |=> startOut) else $error("start late");
  a_start_drop: assert property (
    run && !ctrl[pst_pkg::CTRL_DELAYREL_BIT] && $fell(pickUp)
    |-> ##[1:2] !startOut) else $error("start not cleared");
  a_start_hold: assert property (
    run && ctrl[pst_pkg::CTRL_DELAYREL_BIT] && startOut && !tripOut
    && rel > 16'h0001 && $fell(pickUp) |=> dropHeld)
    else $error("start dropped early");
  a_no_trip_rel: assert property (
    quiet ##0 !tripOut |=> !tripOut) else $error("trip without pick-up");
  a_trip_clear: assert property (
    !frcOn && tripOut && $fell(pickUp) |-> ##[1:2] !tripOut)
    else $error("trip stuck");
  a_force_trip: assert property (
    (frcAct && frc == pst_pkg::FORCE_TRIP) [*2] |-> tripOut && !blockedOut)
    else $error("forced trip missing");
  a_force_block: assert property (
    (frcAct && frc == pst_pkg::FORCE_BLOCKED) [*2] |-> blockedOut && !tripOut)
    else $error("forced block missing");
  a_force_norm: assert property (
    (frcAct && frc == pst_pkg::FORCE_NORMAL) [*2]
    |-> !startOut && !tripOut && !blockedOut) else $error("forced normal");
  a_block_free: assert property (
    !frcOn [*2] |-> !blockedOut) else $error("blocked without forcing");
endmodule // pst_checker
bind pst_stage_timer pst_checker #(.MS_TICK_CYCLES(MS_TICK_CYCLES)) i_chk (
  .clk_sys(clk_sys), .srst(srst), .apbReq(apbReq), .apbRsp(apbRsp),
  .measCurrent(measCurrent), .pickUp(pickUp), .startOut(startOut),
  .tripOut(tripOut), .blockedOut(blockedOut), .irq(irq));
`default_nettype wire

// ---- test/tb.sv ----
// Self-checking bench for the protection stage delay timer.
`timescale 1ns/1ps
`default_nettype none
module tb;
  localparam int TK = 10;
  logic                  clk_sys = 1'h0;
  logic                  srst = 1'h1;
  pst_pkg::pst_apb_req_t apbReq = '0;
  pst_pkg::pst_apb_rsp_t apbRsp;
  logic [15:0]           measCurrent = 16'h0000;
  logic                  pickUp = 1'h0;
  logic                  startOut, tripOut, blockedOut, irq;
  logic [31:0]           rd;
  logic                  err;
  integer                seed = 32'he605_810c;
  int                    n_mismatch = 0;
  int                    tests_run = 0;
  int                    c;
  int                    dl;
  int                    ev[4];
  int                    cm[4] = '{5, 13, 13, 21};
  int                    gp[4] = '{20, 20, 80, 20};

  always #5 clk_sys = ~clk_sys;

  pst_stage_timer #(.MS_TICK_CYCLES(TK)) i_dut (
    .clk_sys(clk_sys), .srst(srst), .apbReq(apbReq), .apbRsp(apbRsp),
    .measCurrent(measCurrent), .pickUp(pickUp), .startOut(startOut),
    .tripOut(tripOut), .blockedOut(blockedOut), .irq(irq));

  task automatic test_done;
    $display("%0d checks, %0d mismatches", tests_run, n_mismatch);
    if (n_mismatch == 0 && tests_run > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask

  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    tests_run++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("wrong value at %0t: got %0h, want %0h", $time, seen, exp);
    end
  endtask

  // Curve results are fixed point, so a tolerance band is accepted.
  task automatic near(input logic [31:0] seen, input int exp, input int tol);
    if ($signed(seen) >= exp - tol && $signed(seen) <= exp + tol) begin
      check(seen, seen);
    end else begin
      check(seen, exp);
    end
  endtask

  task automatic apb(input logic w, input logic [11:0] a, input int d);
    int k;
    @(posedge clk_sys);
    apbReq <= '{psel: 1'h1, penable: 1'h0, pwrite: w, paddr: a, pwdata: d};
    @(posedge clk_sys);
    apbReq.penable <= 1'h1;
    for (k = 0; k < 20; k++) begin
      @(posedge clk_sys);
      if (apbRsp.pready === 1'h1) break;
    end
    if (k == 20) begin
      check(1'h0, 1'h1);
      test_done();
    end
    rd = apbRsp.prdata;
    err = apbRsp.pslverr;
    apbReq.psel <= 1'h0;
    apbReq.penable <= 1'h0;
  endtask

  task automatic wr(input logic [11:0] a, input int d);
    apb(1'h1, a, d);
  endtask

  task automatic rdc(input logic [11:0] a, input logic [31:0] exp);
    apb(1'h0, a, 0);
    check(rd, exp);
  endtask

  task automatic hold(input logic v, input int cyc);
    @(posedge clk_sys);
    pickUp <= v;
    repeat (cyc) @(posedge clk_sys);
  endtask

  // Counts cycles until start or trip reaches the level; a hang ends the run.
  task automatic waitOut(input logic trip, input logic lvl);
    c = 0;
    while ((trip ? tripOut : startOut) !== lvl) begin
      @(posedge clk_sys);
      c++;
      if (c > 5000) begin
        check(c, 0);
        test_done();
      end
    end
  endtask

  function automatic int rnd(int lo, int span);
    return lo + int'($unsigned($random(seed)) % span);
  endfunction

  function automatic int mechMs(int d, int s, int m);
    return $rtoi(d * 10.0 / (0.339 - 0.236 * s / m));
  endfunction

  function automatic int logMs(int d, int s, int m);
    real t;
    t = 5800.0 - 1350.0 * $ln(m * 100.0 / (d * s));
    return t < 0.0 ? 0 : $rtoi(t);
  endfunction

  initial begin
    int s, d, m, cv, r;
    repeat (16) @(posedge clk_sys);
    srst <= 1'h0;
    rdc(pst_pkg::ADDR_CTRL, 32'h0000_000c);
    rdc(pst_pkg::ADDR_RELEASE, 32'h0000_000c);
    rdc(12'h02c, 32'h0000_0000);
    check(err, 1'h1);
    $display("test reset done");
    for (int i = 0; i < 16; i++) begin
      cv = i % 2;
      s = rnd(50, 150);
      d = rnd(5, 95);
      m = s + rnd(1, cv ? 2000 : 400);
      wr(pst_pkg::ADDR_CTRL, 12 + 2 * cv);
      wr(pst_pkg::ADDR_DIAL, d);
      wr(pst_pkg::ADDR_PICKUP, s);
      measCurrent <= 16'(m);
      repeat (4) @(posedge clk_sys);
      apb(1'h0, pst_pkg::ADDR_OPDELAY, 0);
      if (cv) near(rd, logMs(d, s, m), logMs(d, s, m) / 25 + 100);
      else near(rd, mechMs(d, s, m), mechMs(d, s, m) / 50 + 3);
    end
    $display("test curves done");
    wr(pst_pkg::ADDR_CTRL, 15);
    wr(pst_pkg::ADDR_DIAL, 10);
    wr(pst_pkg::ADDR_PICKUP, 50);
    measCurrent <= 16'h03e8;
    repeat (4) @(posedge clk_sys);
    rdc(pst_pkg::ADDR_OPDELAY, 32'h0000_0000);
    hold(1'h1, 0);
    waitOut(1'h1, 1'h1);
    near(c, 1, 2);
    hold(1'h0, 0);
    waitOut(1'h0, 1'h0);
    $display("test instant done");
    wr(pst_pkg::ADDR_DIAL, 1);
    wr(pst_pkg::ADDR_PICKUP, 100);
    wr(pst_pkg::ADDR_IRQ_ENABLE, 1);
    wr(pst_pkg::ADDR_CTRL, 13);
    wr(pst_pkg::ADDR_IRQ_CLEAR, 7);
    dl = mechMs(1, 100, 1000);
    hold(1'h1, 0);
    waitOut(1'h1, 1'h1);
    near(c / TK, dl, 2);
    check(irq, 1'h1);
    rdc(pst_pkg::ADDR_IRQ_STATUS, 32'h0000_0003);
    wr(pst_pkg::ADDR_IRQ_CLEAR, 7);
    @(posedge clk_sys);
    check(irq, 1'h0);
    wr(pst_pkg::ADDR_IRQ_ENABLE, 0);
    hold(1'h0, 70 * TK);
    // Pick-up, gap, pick-up again: the remaining time shows the mode.
    ev = '{dl, dl - 15, dl, 0};
    for (int i = 0; i < 4; i++) begin
      wr(pst_pkg::ADDR_CTRL, cm[i]);
      hold(1'h1, 15 * TK);
      hold(1'h0, gp[i] * TK);
      check(tripOut, 1'h0);
      hold(1'h1, 0);
      waitOut(1'h1, 1'h1);
      near(c / TK, ev[i], 2);
      hold(1'h0, 70 * TK);
    end
    check(irq, 1'h0);
    rdc(pst_pkg::ADDR_IRQ_STATUS, 32'h0000_0007);
    $display("test release modes done");
    r = rnd(2, 8);
    wr(pst_pkg::ADDR_RELEASE, r);
    wr(pst_pkg::ADDR_CTRL, 5);
    hold(1'h1, 5 * TK);
    hold(1'h0, 0);
    waitOut(1'h0, 1'h0);
    near(c / TK, r * 5, 1);
    wr(pst_pkg::ADDR_CTRL, 1);
    hold(1'h1, 5 * TK);
    hold(1'h0, 0);
    waitOut(1'h0, 1'h0);
    near(c, 1, 1);
    $display("test start release done");
    wr(pst_pkg::ADDR_CTRL, 33);
    hold(1'h1, 0);
    for (int f = 0; f < 4; f++) begin
      wr(pst_pkg::ADDR_FORCE, f);
      repeat (3) @(posedge clk_sys);
      check({blockedOut, tripOut}, f == 3 ? 2 : f == 2 ? 1 : 0);
      if (f < 2) check(startOut, f == 1);
    end
    hold(1'h0, 0);
    wr(pst_pkg::ADDR_CTRL, 1);
    $display("test forcing done");
    test_done();
  end
endmodule // tb
`default_nettype wire
